// ### verilog/csq_pkg.sv
// Functional notes
// - direction field: 01 reads only, 10 writes only, 11 both, 00 reserved never asserts
// - asynchronous mode: strobe select 0 follows address strobe, 1 follows data strobe
// - acknowledge code 1111 leaves cycle termination to external acknowledge
// - codes 0000 to 1101 insert that many wait states before internal acknowledge
// - code 1110 is fast termination: access completes in two clocks
// - space field: 00 cpu, 01 user, 10 supervisor, 11 supervisor or user
// - cpu space: during interrupt acknowledge compare address level bits with level field
// - level code 000 matches any acknowledge level, 001 to 111 only that level
// - level field affects only chip select, never interrupt recognition
// - mode 0 follows bus strobes, mode 1 synchronises with the e phase clock
// - synchronous mode ignores acknowledge field and flags a pending e clock cycle
// - sixteen-bit port: byte field 00 off, 01 lower, 10 upper, 11 both
package csq_pkg;

  localparam logic [7:0] OFS_OPTION = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [15:0] OPTION_RESET = 16'h0000;

  localparam logic [1:0] DIR_RESERVED = 2'b00;
  localparam logic [1:0] DIR_READ = 2'b01;
  localparam logic [1:0] DIR_WRITE = 2'b10;
  localparam logic [1:0] SPACE_CPU = 2'b00;
  localparam logic [1:0] SPACE_USER = 2'b01;
  localparam logic [1:0] SPACE_SUPV = 2'b10;
  localparam logic [1:0] SPACE_BOTH = 2'b11;
  localparam logic [1:0] BYTE_OFF = 2'b00;
  localparam logic [1:0] BYTE_LOWER = 2'b01;
  localparam logic [1:0] BYTE_UPPER = 2'b10;
  localparam logic [3:0] ACK_FAST = 4'he;
  localparam logic [3:0] ACK_EXT = 4'hf;
  localparam logic [2:0] LEVEL_ANY = 3'h0;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // option register layout, msb first
  typedef struct packed {
    logic mode;
    logic [1:0] byte_sel;
    logic [1:0] dir;
    logic strobe_select;
    logic [3:0] ack_code;
    logic [1:0] space;
    logic [2:0] irq_level_match;
    logic autovec;
  } csq_option_t;

  // one bus cycle as offered by the internal bus master
  typedef struct packed {
    logic base_match;
    logic read;
    logic [1:0] space;
    logic iack;
    logic [2:0] addr_level;
    logic [1:0] lanes;
    logic port16;
  } csq_cycle_t;

  typedef enum {ST_IDLE, ST_WAIT, ST_ACK} csq_state_t;

endpackage : csq_pkg

// ### verilog/csq_qualifier.sv
// chip select option qualifier with axi4-lite option/status registers
`timescale 1ns/1ns
module csq_qualifier (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire csq_pkg::csq_cycle_t cyc,
  input wire logic addr_strobe_n,
  input wire logic data_strobe_n,
  input wire logic e_phase_clock,
  output logic chip_select_n,
  output logic cycle_term_ack,
  output logic ext_ack_select,
  output logic e_cycle_pending
);

  // ---------------- register bus ----------------
  logic [15:0] chip_select_option_q, chip_select_option_d;
  logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic wr_take, rd_take;
  logic [31:0] status_word;
  csq_pkg::csq_option_t opt;

  // cycle side state, declared here because status reads it
  csq_pkg::csq_state_t state_q, state_d;
  logic [3:0] wait_q, wait_d;
  logic cs_q, cs_d, ack_q, ack_d, epend_q, epend_d, ext_q, ext_d;

  assign opt = csq_pkg::csq_option_t'(chip_select_option_q);

  // write address and data are only taken together; the master offers both at once
  assign wr_take = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
  assign rd_take = s_axi_arvalid && !rvalid_q;
  assign s_axi_awready = wr_take;
  assign s_axi_wready = wr_take;
  assign s_axi_arready = rd_take;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;

  assign status_word = {24'h0, e_cycle_pending, wait_q, ext_q, ack_q, !chip_select_n};

  always_comb begin
    chip_select_option_d = chip_select_option_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    if (wr_take) begin
      bvalid_d = 1'b1;
      bresp_d = csq_pkg::RESP_OKAY;
      if (s_axi_awaddr[7:2] == csq_pkg::OFS_OPTION[7:2]) begin
        if (s_axi_wstrb[0]) begin
          chip_select_option_d[7:0] = s_axi_wdata[7:0];
        end
        if (s_axi_wstrb[1]) begin
          chip_select_option_d[15:8] = s_axi_wdata[15:8];
        end
      end else if (s_axi_awaddr[7:2] != csq_pkg::OFS_STATUS[7:2]) begin
        bresp_d = csq_pkg::RESP_SLVERR;
      end
    end
    if (rd_take) begin
      rvalid_d = 1'b1;
      rresp_d = csq_pkg::RESP_OKAY;
      rdata_d = 32'h0;
      if (s_axi_araddr[7:2] == csq_pkg::OFS_OPTION[7:2]) begin
        rdata_d = {16'h0, chip_select_option_q};
      end else if (s_axi_araddr[7:2] == csq_pkg::OFS_STATUS[7:2]) begin
        rdata_d = status_word;
      end else begin
        rresp_d = csq_pkg::RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chip_select_option_q <= csq_pkg::OPTION_RESET;
      bvalid_q <= 1'b0;
      bresp_q <= csq_pkg::RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q <= csq_pkg::RESP_OKAY;
      rdata_q <= 32'h0;
    end else begin
      chip_select_option_q <= chip_select_option_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
    end
  end

  // ---------------- qualification ----------------
  function automatic logic dir_ok(input logic [1:0] dir, input logic read);
    dir_ok = (dir != csq_pkg::DIR_RESERVED)
          && !(dir == csq_pkg::DIR_READ && !read)
          && !(dir == csq_pkg::DIR_WRITE && read);
  endfunction : dir_ok

  function automatic logic space_ok(input csq_pkg::csq_option_t o, input csq_pkg::csq_cycle_t c);
    case (o.space)
      // level compare only in cpu space; interrupt recognition is untouched here
      csq_pkg::SPACE_CPU: space_ok = c.space == csq_pkg::SPACE_CPU && c.iack
        && (o.irq_level_match == csq_pkg::LEVEL_ANY || o.irq_level_match == c.addr_level);
      csq_pkg::SPACE_USER: space_ok = c.space == csq_pkg::SPACE_USER;
      csq_pkg::SPACE_SUPV: space_ok = c.space == csq_pkg::SPACE_SUPV;
      default: space_ok = c.space == csq_pkg::SPACE_USER || c.space == csq_pkg::SPACE_SUPV;
    endcase
  endfunction : space_ok

  function automatic logic byte_ok(input logic [1:0] sel, input csq_pkg::csq_cycle_t c);
    if (!c.port16) begin
      byte_ok = 1'b1;
    end else begin
      case (sel)
        csq_pkg::BYTE_OFF: byte_ok = 1'b0;
        csq_pkg::BYTE_LOWER: byte_ok = c.lanes[0];
        csq_pkg::BYTE_UPPER: byte_ok = c.lanes[1];
        default: byte_ok = |c.lanes;
      endcase
    end
  endfunction : byte_ok

  logic qual, strobe_ok;
  assign qual = !addr_strobe_n && cyc.base_match && dir_ok(opt.dir, cyc.read)
             && space_ok(opt, cyc)
             && byte_ok(opt.byte_sel, cyc);
  assign strobe_ok = opt.strobe_select ? !data_strobe_n : !addr_strobe_n;

  assign chip_select_n = !cs_q;
  assign cycle_term_ack = ack_q;
  assign ext_ack_select = ext_q;
  assign e_cycle_pending = epend_q;

  always_comb begin
    state_d = state_q;
    wait_d = wait_q;
    ack_d = ack_q;
    // mode 1 tracks the e phase clock, mode 0 the bus strobes
    cs_d = opt.mode ? (qual && e_phase_clock) : (qual && strobe_ok);
    epend_d = qual && opt.mode;
    ext_d = qual && !opt.mode && opt.ack_code == csq_pkg::ACK_EXT;
    case (state_q)
      csq_pkg::ST_IDLE: begin
        ack_d = 1'b0;
        // synchronous cycles and external acknowledge never start the counter
        if (cs_d && !opt.mode && opt.ack_code != csq_pkg::ACK_EXT) begin
          if (opt.ack_code == csq_pkg::ACK_FAST) begin
            state_d = csq_pkg::ST_ACK;
            ack_d = 1'b1;
          end else begin
            state_d = csq_pkg::ST_WAIT;
            wait_d = opt.ack_code;
          end
        end
      end
      csq_pkg::ST_WAIT: begin
        if (!qual) begin
          state_d = csq_pkg::ST_IDLE;
          wait_d = 4'h0;
        end else if (wait_q == 4'h0) begin
          state_d = csq_pkg::ST_ACK;
          ack_d = 1'b1;
        end else begin
          wait_d = wait_q - 4'h1;
        end
      end
      csq_pkg::ST_ACK: begin
        // acknowledge stays until the qualification drops
        if (!qual) begin
          state_d = csq_pkg::ST_IDLE;
          ack_d = 1'b0;
        end
      end
      default: begin
        state_d = csq_pkg::ST_IDLE;
        ack_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= csq_pkg::ST_IDLE;
      wait_q <= 4'h0;
      cs_q <= 1'b0;
      ack_q <= 1'b0;
      epend_q <= 1'b0;
      ext_q <= 1'b0;
    end else begin
      state_q <= state_d;
      wait_q <= wait_d;
      cs_q <= cs_d;
      ack_q <= ack_d;
      epend_q <= epend_d;
      ext_q <= ext_d;
    end
  end

  // ---------------- checks ----------------
  logic [4:0] cs_age_q, cs_age_d;
  // edges since chip select asserted, for the wait count check
  always_comb begin
    cs_age_d = cs_q ? cs_age_q + 5'h1 : 5'h0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cs_age_q <= 5'h0;
    end else begin
      cs_age_q <= cs_age_d;
    end
  end

  chk_dir_qual: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(cs_q) |-> $past(opt.dir) != csq_pkg::DIR_RESERVED
      && !($past(opt.dir) == csq_pkg::DIR_READ && !$past(cyc.read))
      && !($past(opt.dir) == csq_pkg::DIR_WRITE && $past(cyc.read)))
    else $error("chip select asserted against direction field");

  chk_strobe_align: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(cs_q) && !$past(opt.mode) |->
      ($past(opt.strobe_select) ? !$past(data_strobe_n) : !$past(addr_strobe_n)))
    else $error("asynchronous chip select not aligned to selected strobe");

  chk_ext_ack: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(ack_q) |-> $past(opt.ack_code) != csq_pkg::ACK_EXT && !$past(opt.mode))
    else $error("internal acknowledge with external or synchronous setting");

  chk_wait_count: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(ack_q) && $past(opt.ack_code) < csq_pkg::ACK_FAST |->
      cs_age_q == {1'b0, $past(opt.ack_code)} + 5'h1)
    else $error("wait state count differs from acknowledge code");

  chk_fast_term: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(cs_q) && $past(opt.ack_code) == csq_pkg::ACK_FAST && !$past(opt.mode) |-> ack_q)
    else $error("fast termination did not acknowledge with chip select");

  chk_space_match: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(cs_q) && $past(opt.space) != csq_pkg::SPACE_CPU |->
      $past(cyc.space) != csq_pkg::SPACE_CPU
      && ($past(opt.space) == csq_pkg::SPACE_BOTH || $past(opt.space) == $past(cyc.space)))
    else $error("chip select asserted in wrong address space");

  chk_level_match: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(cs_q) && $past(opt.space) == csq_pkg::SPACE_CPU |-> $past(cyc.iack)
      && ($past(opt.irq_level_match) == csq_pkg::LEVEL_ANY
        || $past(opt.irq_level_match) == $past(cyc.addr_level)))
    else $error("acknowledge chip select with mismatched level");

  chk_sync_e_phase_clock: assert property (@(posedge aclk) disable iff (!aresetn)
    cs_q && $past(opt.mode) |-> $past(e_phase_clock))
    else $error("synchronous chip select outside e clock phase");

  chk_sync_pending: assert property (@(posedge aclk) disable iff (!aresetn)
    qual && opt.mode |=> epend_q && !$rose(ack_q))
    else $error("synchronous match did not flag pending e cycle");

  chk_byte_lane: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(cs_q) |-> $past(cyc.base_match)
      && !($past(cyc.port16) && $past(opt.byte_sel) == csq_pkg::BYTE_OFF))
    else $error("chip select without base match or with byte option off");

  chk_ack_release: assert property (@(posedge aclk) disable iff (!aresetn)
    ack_q && !qual |=> !ack_q)
    else $error("acknowledge held after qualification dropped");

  chk_ext_select: assert property (@(posedge aclk) disable iff (!aresetn)
    ext_q |-> $past(qual) && !$past(opt.mode) && $past(opt.ack_code) == csq_pkg::ACK_EXT)
    else $error("external acknowledge selected outside qualified asynchronous cycle");

  chk_cs_in_cycle: assert property (@(posedge aclk) disable iff (!aresetn)
    cs_q |-> !$past(addr_strobe_n))
    else $error("chip select asserted outside a bus cycle");

endmodule : csq_qualifier

// ### verification/csq_ext_periph.sv
// external peripheral model: measures acknowledge latency seen at the pins
`timescale 1ns/1ns
module csq_ext_periph (
  input wire logic aclk,
  input wire logic chip_select_n,
  input wire logic cycle_term_ack,
  input wire logic ext_ack_select,
  output logic [4:0] wait_q,
  output logic ext_ack_q
);
  logic [4:0] wait_d;
  logic ext_ack_d;
  always_comb begin
    wait_d = wait_q;
    if (chip_select_n) begin
      wait_d = 5'h00;
    end else if (!cycle_term_ack && wait_q != 5'h1f) begin
      wait_d = wait_q + 5'h01;
    end
    // the peripheral would drive its own acknowledge here
    ext_ack_d = ext_ack_select & !chip_select_n;
  end
  always_ff @(posedge aclk) begin
    wait_q <= wait_d;
    ext_ack_q <= ext_ack_d;
  end
endmodule : csq_ext_periph

// ### verification/csq_qualifier_tb_top.sv
// self-checking testbench for the chip select option qualifier
`timescale 1ns/1ns
module csq_qualifier_tb_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, cs_n, ack, ext_sel, pend, ext_seen;
  logic [1:0] bresp, rresp, r;
  logic as_n = 1'b1, ds_n = 1'b1, e_clk = 1'b0, ds, e, q;
  logic [4:0] wait_seen;
  logic [31:0] d;
  csq_pkg::csq_cycle_t cyc = '0, cb;
  csq_pkg::csq_option_t o;
  integer seed = 32'h2f52;
  int bad_count = 0, n_checks = 0, tick = 0;

  csq_qualifier i_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .cyc(cyc), .addr_strobe_n(as_n), .data_strobe_n(ds_n), .e_phase_clock(e_clk),
    .chip_select_n(cs_n), .cycle_term_ack(ack), .ext_ack_select(ext_sel), .e_cycle_pending(pend));
  csq_ext_periph i_periph (.aclk(aclk), .chip_select_n(cs_n), .cycle_term_ack(ack),
    .ext_ack_select(ext_sel), .wait_q(wait_seen), .ext_ack_q(ext_seen));

  always #10 aclk = ~aclk;

  task automatic results();
    $display("checks %0d errors %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results

  // long enough for 16 acknowledge runs plus the random loop
  always @(posedge aclk) begin
    tick <= tick + 1;
    if (tick == 20000) begin
      bad_count++;
      results();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge aclk); while (!awready);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge aclk); while (!bvalid);
    rs = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask : rd

  task automatic setopt(input csq_pkg::csq_option_t ov);
    wr(csq_pkg::OFS_OPTION, {16'h0, ov}, r);
    chk("wresp", r, csq_pkg::RESP_OKAY);
    rd(csq_pkg::OFS_OPTION, d, r);
    chk("opt_rb", d, {16'h0, ov});
  endtask : setopt

  // bus cycle held with the address strobe low for n edges
  task automatic bc(input csq_pkg::csq_cycle_t c, input logic dsv, input logic ev, input int n);
    @(posedge aclk);
    cyc <= c;
    as_n <= 1'b0;
    ds_n <= dsv;
    e_clk <= ev;
    repeat (n) @(posedge aclk);
  endtask : bc

  task automatic rel();
    as_n <= 1'b1;
    ds_n <= 1'b1;
    repeat (3) @(posedge aclk);
  endtask : rel

  function automatic logic qual_f(input csq_pkg::csq_option_t ov, input csq_pkg::csq_cycle_t c);
    return c.base_match & (c.read ? ov.dir[0] : ov.dir[1])
      & ((ov.space == csq_pkg::SPACE_CPU) ? (c.space == csq_pkg::SPACE_CPU && c.iack
        && (ov.irq_level_match == csq_pkg::LEVEL_ANY || ov.irq_level_match == c.addr_level))
        : ((ov.space & c.space) != 2'b00))
      & (!c.port16 || ((ov.byte_sel & c.lanes) != 2'b00));
  endfunction : qual_f

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd(csq_pkg::OFS_OPTION, d, r);
    chk("opt_reset", d, {16'h0, csq_pkg::OPTION_RESET});
    rd(8'h10, d, r);
    chk("rresp_unmapped", r, csq_pkg::RESP_SLVERR);
    chk("rdata_unmapped", d, 32'h0);
    wr(8'h10, 32'hffff, r);
    chk("bresp_unmapped", r, csq_pkg::RESP_SLVERR);
    wr(csq_pkg::OFS_STATUS, 32'hff, r);
    chk("bresp_status", r, csq_pkg::RESP_OKAY);
    for (int k = 0; k < 16; k++) begin
      o = '0;
      o.byte_sel = 2'b11;
      o.dir = 2'b11;
      o.space = csq_pkg::SPACE_BOTH;
      o.ack_code = k[3:0];
      setopt(o);
      cb = '0;
      cb.base_match = 1'b1;
      cb.read = 1'b1;
      cb.space = csq_pkg::SPACE_USER;
      cb.lanes = 2'b11;
      bc(cb, 1'b0, 1'b0, 20);
      if (k < 15) chk("wait", wait_seen, (k == 14) ? 0 : k + 1);
      chk("ack", ack, k < 15);
      chk("ext_ack", ext_seen, k == 15);
      rd(csq_pkg::OFS_STATUS, d, r);
      chk("status", d, {29'h0, k == 15, k < 15, 1'b1});
      rel();
      chk("cs_off", cs_n, 1'b1);
      chk("ack_off", ack, 1'b0);
    end
    for (int i = 0; i < 150; i++) begin
      o = 16'($random(seed));
      setopt(o);
      cb = 11'($random(seed));
      if (cb.space == 2'b11) cb.space = csq_pkg::SPACE_CPU;
      if (cb.space != csq_pkg::SPACE_CPU) cb.iack = 1'b0;
      if (cb.lanes == 2'b00) cb.lanes = 2'b01;
      if ($random(seed) & 1) cb.addr_level = o.irq_level_match;
      if ($random(seed) & 3) cb.base_match = 1'b1;
      ds = 1'($random(seed));
      e = 1'($random(seed));
      q = qual_f(o, cb);
      bc(cb, ds, e, 3);
      chk("cs", cs_n, !(q & (o.mode ? e : (!o.strobe_select | !ds))));
      chk("pending", pend, q & o.mode);
      if (o.mode) chk("sync_ack", ack, 1'b0);
      rel();
    end
    results();
  end
endmodule : csq_qualifier_tb_top
